// ==== rtl/pel_defines.svh ====
// offsets, field positions and reset values of the port status and link capability registers
`ifndef PEL_DEFINES_SVH
`define PEL_DEFINES_SVH

// ------------------------------------------------------------
// register offsets (byte addresses in configuration space)
// ------------------------------------------------------------
`define PEL_OFF_DEV_ERR_STATUS 12'h0C8
`define PEL_OFF_LINK_CAPS 12'h0CC
`define PEL_ADDR_W 12

// ------------------------------------------------------------
// device control / status word at the error status offset
// ------------------------------------------------------------
`define PEL_RPT_EN_RANGE 3:0
`define PEL_ERR_RANGE 19:16
`define PEL_ERR_COR_BIT 16
`define PEL_ERR_NFAT_BIT 17
`define PEL_ERR_FAT_BIT 18
`define PEL_ERR_UR_BIT 19
`define PEL_AUX_BIT 20
`define PEL_TPEND_BIT 21
`define PEL_RPT_EN_RST 4'h0
`define PEL_AUX_RST 1'h1
`define PEL_TPEND_VAL 1'h0
`define PEL_CTL_LANE 0
`define PEL_STS_LANE 2

// ------------------------------------------------------------
// link capability fields
// ------------------------------------------------------------
`define PEL_SPD_RANGE 3:0
`define PEL_WID_RANGE 9:4
`define PEL_ASPM_RANGE 11:10
`define PEL_L0S_RANGE 14:12
`define PEL_L1_RANGE 17:15
`define PEL_CLKPM_BIT 18
`define PEL_SDOWN_BIT 19
`define PEL_DLLA_BIT 20
`define PEL_BWN_BIT 21
`define PEL_PORT_RANGE 31:24
`define PEL_SPD_2G5 4'h1
`define PEL_SPD_5G0 4'h2
`define PEL_SPD_RST 4'h2
`define PEL_WID_RST 6'h01
`define PEL_ASPM_RST 2'h3
`define PEL_L0S_RST 3'h3
`define PEL_L1_RST 3'h0
`define PEL_CAP_RSVD_MASK 32'h00C00000
`define PEL_CAP_DLLA_MASK 32'h00100000

`endif

// ==== rtl/pel_pkg.sv ====
// state types of the port status and link capability register bank
package pel_pkg;

    // state of the sticky error flag bank
    typedef struct packed {
        logic [3:0] flags;
    } pel_flag_s;

    // state of the overridable capability word
    typedef struct packed {
        logic [31:0] word;
    } pel_cap_s;

    // state of the top-level register bank
    typedef struct packed {
        logic [3:0] rpt_en;
        logic aux;
        logic ack;
        logic [31:0] rdata;
        logic [3:0] msg;
    } pel_top_s;

endpackage

// ==== rtl/pel_w1c_flags.sv ====
// sticky event flags, set by hardware and cleared by writing one
`timescale 1ns/1ps
`default_nettype none

module pel_w1c_flags #(
    parameter int WIDTH = 4
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] set_i,
    input wire logic [WIDTH-1:0] clr_i,
    output logic [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // set beats clear so an event in the clearing cycle is never lost
    always_comb begin
        flags_d = (flags_q & ~clr_i) | set_i;
    end

    // flags start clear after reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule // pel_w1c_flags

`default_nettype wire

// ==== rtl/pel_cap_reg.sv ====
// link capability word with per-port defaults and management override
`timescale 1ns/1ps
`default_nettype none
`include "pel_defines.svh"

module pel_cap_reg #(
    parameter bit IS_UP = 1'b1,
    parameter logic [7:0] PORT_NUM = 8'h00
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ovr_wr,
    input wire logic [3:0] ovr_be,
    input wire logic [31:0] ovr_wdata,
    output logic [31:0] cap_word
);

    // ------------------------------------------------------------
    // reset image
    // ------------------------------------------------------------
    localparam logic [31:0] CAP_RST = {PORT_NUM, 2'h0,
        ~IS_UP, 1'b0, ~IS_UP, IS_UP,
        `PEL_L1_RST, `PEL_L0S_RST, `PEL_ASPM_RST,
        `PEL_WID_RST, `PEL_SPD_RST};
    localparam logic [31:0] HW_ZERO = `PEL_CAP_RSVD_MASK |
        (IS_UP ? `PEL_CAP_DLLA_MASK : 32'h00000000);

    pel_pkg::pel_cap_s cap_q;
    pel_pkg::pel_cap_s cap_d;
    logic [31:0] merged;

    // byte-lane merge of new data over the old word
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // override path
    // ------------------------------------------------------------
    // a reserved speed code is refused so the field never shows one
    always_comb begin
        cap_d = cap_q;
        merged = lane_merge(cap_q.word, ovr_wdata, ovr_be);
        if (merged[`PEL_SPD_RANGE] != `PEL_SPD_2G5 && merged[`PEL_SPD_RANGE] != `PEL_SPD_5G0) begin
            merged[`PEL_SPD_RANGE] = cap_q.word[`PEL_SPD_RANGE];
        end
        if (ovr_wr) begin
            cap_d.word = merged & ~HW_ZERO;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cap_q.word <= CAP_RST;
        end else begin
            cap_q <= cap_d;
        end
    end

    assign cap_word = cap_q.word;

endmodule // pel_cap_reg

`default_nettype wire

// ==== rtl/pel_port_regs.sv ====
// per-port device error status and link capability registers of a four-port switch
//
// Summary of operation
// - correctable error event sets sticky bit 16; reset clears it; write one clears
// - non-fatal error event sets sticky bit 17; reset clears; only write one clears
// - fatal error event sets sticky bit 18; reset clears; write one clears
// - unsupported request event sets sticky bit 19; write one clears it
// - error flags log regardless of enables; enables only gate report messages
// - bit 20 shows auxiliary power detected, read only, one after reset
// - transactions pending bit 21 always reads zero
// - max speed field 3:0: 0001b 2.5G, 0010b 5G, others reserved; resets 0010b
// - max width field 9:4 resets to single lane
// - L0s exit latency field 14:12 resets to 011b
// - L1 exit latency field 17:15 resets to 000b
// - capability defaults overridable by management serial port or EEPROM load
// - clock power management bit 18: one upstream, zero downstream after reset
// - surprise down bit 19: zero upstream, one downstream after reset
// - link active reporting bit 20 zero upstream hardwired, zero downstream at reset
// - port number field 31:24 resets to own port index 00h to 03h
// - four report enable bits 3:0 of device control are read-write, reset zero
`timescale 1ns/1ps
`default_nettype none
`include "pel_defines.svh"

module pel_port_regs #(
    parameter logic [7:0] PORT_INDEX = 8'h00
) (
    input wire logic mclk,
    input wire logic rst,
    // configuration access from host software
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [11:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack,
    output logic [31:0] cfg_rdata,
    // error detection events from the port logic
    input wire logic err_cor,
    input wire logic err_nonfatal,
    input wire logic err_fatal,
    input wire logic err_unsup,
    input wire logic aux_pwr_det,
    // management serial port or EEPROM loader writes
    input wire logic mgmt_wr,
    input wire logic [11:0] mgmt_addr,
    input wire logic [3:0] mgmt_be,
    input wire logic [31:0] mgmt_wdata,
    // error report messages and state views
    output logic rpt_cor,
    output logic rpt_nonfatal,
    output logic rpt_fatal,
    output logic rpt_unsup,
    output logic [3:0] err_flags,
    output logic [31:0] link_caps
);

    // ------------------------------------------------------------
    // local constants
    // ------------------------------------------------------------
    // port zero faces the root, the other three face downstream
    localparam bit IS_UP = (PORT_INDEX == 8'h00);

    pel_pkg::pel_top_s st_q;
    pel_pkg::pel_top_s st_d;
    logic [3:0] err_evt;
    logic [3:0] err_clr;
    logic [3:0] flags;
    logic [31:0] cap_word;
    logic wr_status;
    logic mgmt_cap_wr;
    logic last_rd_status_q;

    // address match, shared by the host and management paths
    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    // ------------------------------------------------------------
    // error event logging
    // ------------------------------------------------------------
    // events are not gated by the enables; logging is unconditional
    assign err_evt = {err_unsup, err_fatal, err_nonfatal, err_cor};

    // write-one clears only act when the status lane is enabled
    assign wr_status = cfg_req && cfg_wr && addr_hit(cfg_addr, `PEL_OFF_DEV_ERR_STATUS);
    assign err_clr = (wr_status && cfg_be[`PEL_STS_LANE]) ?
        cfg_wdata[`PEL_ERR_RANGE] : 4'h0;

    pel_w1c_flags #(
        .WIDTH(4)
    ) u_flags (
        .mclk(mclk),
        .rst(rst),
        .set_i(err_evt),
        .clr_i(err_clr),
        .flags(flags)
    );

    // ------------------------------------------------------------
    // capability word
    // ------------------------------------------------------------
    // host writes to the capability word are ignored; only management writes land
    assign mgmt_cap_wr = mgmt_wr && addr_hit(mgmt_addr, `PEL_OFF_LINK_CAPS);

    pel_cap_reg #(
        .IS_UP(IS_UP),
        .PORT_NUM(PORT_INDEX)
    ) u_cap (
        .mclk(mclk),
        .rst(rst),
        .ovr_wr(mgmt_cap_wr),
        .ovr_be(mgmt_be),
        .ovr_wdata(mgmt_wdata),
        .cap_word(cap_word)
    );

    // ------------------------------------------------------------
    // register bank next state
    // ------------------------------------------------------------
    // one-cycle answer: read data and ack registered on the edge after the request
    always_comb begin
        st_d = st_q;
        st_d.ack = cfg_req;
        st_d.rdata = 32'h00000000;
        st_d.aux = aux_pwr_det;
        // report messages follow an event only while its enable is set
        st_d.msg = err_evt & st_q.rpt_en;
        if (wr_status && cfg_be[`PEL_CTL_LANE]) begin
            st_d.rpt_en = cfg_wdata[`PEL_RPT_EN_RANGE];
        end
        if (cfg_req && !cfg_wr) begin
            if (addr_hit(cfg_addr, `PEL_OFF_DEV_ERR_STATUS)) begin
                st_d.rdata[`PEL_RPT_EN_RANGE] = st_q.rpt_en;
                st_d.rdata[`PEL_ERR_RANGE] = flags;
                st_d.rdata[`PEL_AUX_BIT] = st_q.aux;
                st_d.rdata[`PEL_TPEND_BIT] = `PEL_TPEND_VAL;
            end else if (addr_hit(cfg_addr, `PEL_OFF_LINK_CAPS)) begin
                st_d.rdata = cap_word;
            end
        end
    end

    // all control state has a defined value after reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            st_q.rpt_en <= `PEL_RPT_EN_RST;
            st_q.aux <= `PEL_AUX_RST;
            st_q.ack <= 1'b0;
            st_q.rdata <= 32'h00000000;
            st_q.msg <= 4'h0;
        end else begin
            st_q <= st_d;
        end
    end

    // helper for checks: last read targeted the status word
    always_ff @(posedge mclk) begin
        if (rst) begin
            last_rd_status_q <= 1'b0;
        end else begin
            last_rd_status_q <= cfg_req && !cfg_wr &&
                addr_hit(cfg_addr, `PEL_OFF_DEV_ERR_STATUS);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign cfg_ack = st_q.ack;
    assign cfg_rdata = st_q.rdata;
    assign rpt_cor = st_q.msg[0];
    assign rpt_nonfatal = st_q.msg[1];
    assign rpt_fatal = st_q.msg[2];
    assign rpt_unsup = st_q.msg[3];
    assign err_flags = flags;
    assign link_caps = cap_word;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_cor_set;
        @(posedge mclk) disable iff (rst)
        err_cor |=> err_flags[0];
    endproperty
    a_cor_set: assert property (p_cor_set)
        else $error("correctable flag not set after event");

    property p_nfat_sticky;
        @(posedge mclk) disable iff (rst)
        (err_nonfatal ##1 (!(wr_status && cfg_be[`PEL_STS_LANE]))[*2]) |=> err_flags[1];
    endproperty
    a_nfat_sticky: assert property (p_nfat_sticky)
        else $error("non-fatal flag lost without a clear");

    property p_fat_set;
        @(posedge mclk) disable iff (rst)
        $rose(err_fatal) |=> err_flags[2];
    endproperty
    a_fat_set: assert property (p_fat_set)
        else $error("fatal flag not set after event");

    property p_ur_clear;
        @(posedge mclk) disable iff (rst)
        (wr_status && cfg_be[`PEL_STS_LANE] && cfg_wdata[`PEL_ERR_UR_BIT] && !err_unsup)
            |=> !err_flags[3];
    endproperty
    a_ur_clear: assert property (p_ur_clear)
        else $error("unsupported request flag not cleared by write one");

    property p_log_no_msg;
        @(posedge mclk) disable iff (rst)
        (err_fatal && !st_q.rpt_en[2]) |=> (err_flags[2] && !rpt_fatal);
    endproperty
    a_log_no_msg: assert property (p_log_no_msg)
        else $error("disabled fatal error not logged or still reported");

    property p_msg_en;
        @(posedge mclk) disable iff (rst)
        (err_cor && st_q.rpt_en[0]) |=> rpt_cor;
    endproperty
    a_msg_en: assert property (p_msg_en)
        else $error("enabled correctable error not reported");

    property p_status_read;
        @(posedge mclk) disable iff (rst)
        (cfg_ack && last_rd_status_q) |->
            (!cfg_rdata[`PEL_TPEND_BIT] && cfg_rdata[`PEL_ERR_RANGE] == $past(err_flags)
             && cfg_rdata[31:22] == 10'h000);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status word read back wrong");

    property p_aux_rst;
        @(posedge mclk) disable iff (rst)
        $past(rst) |-> st_q.aux;
    endproperty
    a_aux_rst: assert property (p_aux_rst)
        else $error("aux power indication not one after reset");

    property p_cap_rst;
        @(posedge mclk) disable iff (rst)
        $past(rst) |-> (link_caps[`PEL_SPD_RANGE] == `PEL_SPD_RST
            && link_caps[`PEL_WID_RANGE] == `PEL_WID_RST
            && link_caps[`PEL_ASPM_RANGE] == `PEL_ASPM_RST
            && link_caps[`PEL_L0S_RANGE] == `PEL_L0S_RST
            && link_caps[`PEL_L1_RANGE] == `PEL_L1_RST);
    endproperty
    a_cap_rst: assert property (p_cap_rst)
        else $error("capability fields wrong after reset");

    property p_port_rst;
        @(posedge mclk) disable iff (rst)
        $past(rst) |-> (link_caps[`PEL_PORT_RANGE] == PORT_INDEX
            && link_caps[`PEL_CLKPM_BIT] == IS_UP
            && link_caps[`PEL_SDOWN_BIT] == !IS_UP
            && !link_caps[`PEL_DLLA_BIT]);
    endproperty
    a_port_rst: assert property (p_port_rst)
        else $error("per-port capability defaults wrong after reset");

    property p_speed_legal;
        @(posedge mclk) disable iff (rst)
        link_caps[`PEL_SPD_RANGE] == `PEL_SPD_2G5 || link_caps[`PEL_SPD_RANGE] == `PEL_SPD_5G0;
    endproperty
    a_speed_legal: assert property (p_speed_legal)
        else $error("reserved link speed code held");

    property p_dlla_up;
        @(posedge mclk) disable iff (rst)
        IS_UP |-> !link_caps[`PEL_DLLA_BIT] && link_caps[23:22] == 2'h0;
    endproperty
    a_dlla_up: assert property (p_dlla_up)
        else $error("hardwired capability bit set");

    property p_cap_ro;
        @(posedge mclk) disable iff (rst)
        !mgmt_wr |=> $stable(link_caps);
    endproperty
    a_cap_ro: assert property (p_cap_ro)
        else $error("capability word changed without a management write");

    property p_ovr;
        @(posedge mclk) disable iff (rst)
        (mgmt_cap_wr && mgmt_be[3]) |=> link_caps[`PEL_PORT_RANGE] == $past(mgmt_wdata[31:24]);
    endproperty
    a_ovr: assert property (p_ovr)
        else $error("management override of port number not taken");

    property p_en_rst;
        @(posedge mclk) disable iff (rst)
        $past(rst) |-> st_q.rpt_en == `PEL_RPT_EN_RST;
    endproperty
    a_en_rst: assert property (p_en_rst)
        else $error("report enables not zero after reset");

    property p_w0_keep;
        @(posedge mclk) disable iff (rst)
        (err_flags[0] && wr_status && !cfg_wdata[`PEL_ERR_COR_BIT]) |=> err_flags[0];
    endproperty
    a_w0_keep: assert property (p_w0_keep)
        else $error("write of zero cleared a flag");

    property p_nfat_set;
        @(posedge mclk) disable iff (rst)
        err_nonfatal |=> err_flags[1];
    endproperty
    a_nfat_set: assert property (p_nfat_set)
        else $error("non-fatal flag not set after event");

    property p_ur_set;
        @(posedge mclk) disable iff (rst)
        err_unsup |=> err_flags[3];
    endproperty
    a_ur_set: assert property (p_ur_set)
        else $error("unsupported request flag not set after event");

    property p_cor_clear;
        @(posedge mclk) disable iff (rst)
        (err_clr[0] && !err_cor) |=> !err_flags[0];
    endproperty
    a_cor_clear: assert property (p_cor_clear)
        else $error("correctable flag not cleared by write one");

    property p_aux_read;
        @(posedge mclk) disable iff (rst)
        (cfg_ack && last_rd_status_q) |-> cfg_rdata[`PEL_AUX_BIT] == $past(st_q.aux);
    endproperty
    a_aux_read: assert property (p_aux_read)
        else $error("aux power indication read back wrong");

    property p_en_write;
        @(posedge mclk) disable iff (rst)
        (wr_status && cfg_be[`PEL_CTL_LANE]) |=> st_q.rpt_en == $past(cfg_wdata[3:0]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("report enables not written");

    property p_ur_msg;
        @(posedge mclk) disable iff (rst)
        (err_unsup && st_q.rpt_en[3]) |=> rpt_unsup;
    endproperty
    a_ur_msg: assert property (p_ur_msg)
        else $error("enabled unsupported request not reported");

endmodule // pel_port_regs

`default_nettype wire

// ==== tb/pel_host.sv ====
// host software model that issues configuration reads and writes to one port
`timescale 1ns/1ps
`default_nettype none

module pel_host (
    input wire logic mclk,
    output logic cfg_req,
    output logic cfg_wr,
    output logic [11:0] cfg_addr,
    output logic [3:0] cfg_be,
    output logic [31:0] cfg_wdata,
    input wire logic cfg_ack,
    input wire logic [31:0] cfg_rdata
);
    logic got_ack;

    // idle bus at time zero
    initial begin
        cfg_req = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 12'h000;
        cfg_be = 4'h0;
        cfg_wdata = 32'h00000000;
        got_ack = 1'b0;
    end

    // one access: request held over one rising edge, answer taken while it stands
    task automatic access(input logic wr, input logic [11:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata, output logic [31:0] rdata);
        @(negedge mclk);
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_addr = addr;
        cfg_be = be;
        cfg_wdata = wdata;
        @(negedge mclk);
        got_ack = cfg_ack;
        rdata = cfg_rdata;
        cfg_req = 1'b0;
        // released lines flip so a stale value is never mistaken for fresh data
        cfg_addr = ~addr;
        cfg_be = ~be;
        cfg_wdata = ~wdata;
    endtask
endmodule // pel_host

`default_nettype wire

// ==== tb/tb.sv ====
// testbench for the port error status and link capability registers
`timescale 1ns/1ps
`default_nettype none
`include "pel_defines.svh"

module tb;
    logic mclk, rst, aux_pwr_det, mgmt_wr;
    logic [3:0] err_ev, mgmt_be;
    logic [11:0] mgmt_addr;
    logic [31:0] mgmt_wdata, rd, up_e, dn_e;
    wire logic cfg_req, cfg_wr, cfg_ack, dn_ack;
    wire logic [11:0] cfg_addr;
    wire logic [3:0] cfg_be, rpt, flags, dn_rpt, dn_flags;
    wire logic [31:0] cfg_wdata, cfg_rdata, caps, dn_caps;
    int n_fail, n_compared;

    pel_host host (.mclk(mclk), .cfg_req(cfg_req), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata));

    // upstream port under host control; a downstream port shares every input
    pel_port_regs #(.PORT_INDEX(8'h00)) dut (.mclk(mclk), .rst(rst), .cfg_req(cfg_req),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata), .err_cor(err_ev[0]),
        .err_nonfatal(err_ev[1]), .err_fatal(err_ev[2]), .err_unsup(err_ev[3]),
        .aux_pwr_det(aux_pwr_det), .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr),
        .mgmt_be(mgmt_be), .mgmt_wdata(mgmt_wdata), .rpt_cor(rpt[0]), .rpt_nonfatal(rpt[1]),
        .rpt_fatal(rpt[2]), .rpt_unsup(rpt[3]), .err_flags(flags), .link_caps(caps));
    pel_port_regs #(.PORT_INDEX(8'h03)) dut_dn (.mclk(mclk), .rst(rst), .cfg_req(cfg_req),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack(dn_ack), .cfg_rdata(), .err_cor(err_ev[0]),
        .err_nonfatal(err_ev[1]), .err_fatal(err_ev[2]), .err_unsup(err_ev[3]),
        .aux_pwr_det(aux_pwr_det), .mgmt_wr(mgmt_wr), .mgmt_addr(mgmt_addr),
        .mgmt_be(mgmt_be), .mgmt_wdata(mgmt_wdata), .rpt_cor(dn_rpt[0]),
        .rpt_nonfatal(dn_rpt[1]), .rpt_fatal(dn_rpt[2]), .rpt_unsup(dn_rpt[3]),
        .err_flags(dn_flags), .link_caps(dn_caps));

    // --------------------------------------------------------
    // helpers
    // --------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] want);
        n_compared++;
        if (got !== want) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic rd_chk(input logic [11:0] addr, input logic [31:0] want);
        host.access(1'b0, addr, 4'hF, 32'h00000000, rd);
        cmp_word({30'h0, dn_ack, host.got_ack}, 32'h00000003);
        cmp_word(rd, want);
    endtask

    task automatic wr(input logic [11:0] addr, input logic [3:0] be, input logic [31:0] d);
        host.access(1'b1, addr, be, d, rd);
        cmp_word({30'h0, dn_ack, host.got_ack}, 32'h00000003);
    endtask

    // one-cycle event on error line i, checked once its edge has landed
    task automatic pulse_err(input int i, input logic [3:0] want_rpt);
        @(negedge mclk);
        err_ev[i] = 1'b1;
        @(negedge mclk);
        err_ev = 4'h0;
        cmp_word({24'h0, dn_rpt, rpt}, {24'h0, want_rpt, want_rpt});
    endtask

    task automatic mgmt(input logic [3:0] be, input logic [31:0] d);
        @(negedge mclk);
        mgmt_wr = 1'b1;
        mgmt_be = be;
        mgmt_wdata = d;
        @(negedge mclk);
        mgmt_wr = 1'b0;
        mgmt_wdata = ~d;
    endtask

    function automatic logic [31:0] caps_def(input bit up, input logic [7:0] port);
        logic [31:0] w;
        w = 32'h00000000;
        w[`PEL_SPD_RANGE] = `PEL_SPD_RST;
        w[`PEL_WID_RANGE] = `PEL_WID_RST;
        w[`PEL_ASPM_RANGE] = `PEL_ASPM_RST;
        w[`PEL_L0S_RANGE] = `PEL_L0S_RST;
        w[`PEL_L1_RANGE] = `PEL_L1_RST;
        w[`PEL_CLKPM_BIT] = up;
        w[`PEL_SDOWN_BIT] = !up;
        w[`PEL_BWN_BIT] = !up;
        w[`PEL_PORT_RANGE] = port;
        return w;
    endfunction

    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: the sequence needs well under 1000 cycles
    initial begin
        #100000;
        n_fail++;
        finish_test();
    end

    // --------------------------------------------------------
    // test sequence
    // --------------------------------------------------------
    initial begin
        rst = 1'b1;
        aux_pwr_det = 1'b1;
        err_ev = 4'h0;
        mgmt_wr = 1'b0;
        mgmt_addr = `PEL_OFF_LINK_CAPS;
        mgmt_be = 4'h0;
        mgmt_wdata = 32'h00000000;
        n_fail = 0;
        n_compared = 0;
        up_e = caps_def(1'b1, 8'h00);
        dn_e = caps_def(1'b0, 8'h03);
        repeat (5) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        // reset values of both words on the upstream port and of the capability word on the downstream port
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h00100000);
        rd_chk(`PEL_OFF_LINK_CAPS, up_e);
        cmp_word(dn_caps, dn_e);
        // host writes to read-only places change nothing; unmapped reads give zero
        wr(`PEL_OFF_LINK_CAPS, 4'hF, 32'hFFFFFFFF);
        rd_chk(`PEL_OFF_LINK_CAPS, up_e);
        wr(`PEL_OFF_DEV_ERR_STATUS, 4'hC, 32'hFFF00000);
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h00100000);
        rd_chk(12'h100, 32'h00000000);
        // errors are logged with every enable off and no message goes out
        for (int i = 0; i < 4; i++) begin
            pulse_err(i, 4'h0);
            cmp_word({28'h0, flags}, (32'h2 << i) - 32'h1);
        end
        cmp_word({28'h0, dn_flags}, 32'h0000000F);
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h001F0000);
        wr(`PEL_OFF_DEV_ERR_STATUS, 4'h4, 32'h00000000);
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h001F0000);
        // clearing one flag at a time leaves the others standing
        for (int i = 0; i < 4; i++) begin
            wr(`PEL_OFF_DEV_ERR_STATUS, 4'h4, 32'h00010000 << i);
            cmp_word({28'h0, flags}, 32'hF & ~((32'h2 << i) - 32'h1));
        end
        // with enables set each event gives its own message
        wr(`PEL_OFF_DEV_ERR_STATUS, 4'h1, 32'h0000000F);
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h0010000F);
        for (int i = 0; i < 4; i++) begin
            pulse_err(i, 4'h1 << i);
        end
        wr(`PEL_OFF_DEV_ERR_STATUS, 4'h5, 32'h000F0000);
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h00100000);
        // auxiliary power indication follows its input
        @(negedge mclk);
        aux_pwr_det = 1'b0;
        repeat (2) @(negedge mclk);
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h00000000);
        aux_pwr_det = 1'b1;
        // management overrides: port number, speed codes, bits 23:16 with forced bits
        mgmt(4'h8, 32'h07000000);
        up_e[`PEL_PORT_RANGE] = 8'h07;
        dn_e[`PEL_PORT_RANGE] = 8'h07;
        cmp_word(caps, up_e);
        mgmt(4'h1, 32'h00000011);
        up_e[`PEL_SPD_RANGE] = `PEL_SPD_2G5;
        dn_e[`PEL_SPD_RANGE] = `PEL_SPD_2G5;
        cmp_word(caps, up_e);
        mgmt(4'h1, 32'h00000015);
        cmp_word(caps, up_e);
        // a management write aimed at another offset leaves the word alone
        mgmt_addr = `PEL_OFF_DEV_ERR_STATUS;
        mgmt(4'hF, 32'h00000000);
        cmp_word(caps, up_e);
        mgmt_addr = `PEL_OFF_LINK_CAPS;
        mgmt(4'h4, 32'h00FF0000);
        up_e[23:16] = 8'h2F;
        dn_e[23:16] = 8'h3F;
        cmp_word(caps, up_e);
        cmp_word(dn_caps, dn_e);
        rd_chk(`PEL_OFF_LINK_CAPS, up_e);
        // a second reset brings back every default
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        cmp_word(caps, caps_def(1'b1, 8'h00));
        cmp_word(dn_caps, caps_def(1'b0, 8'h03));
        cmp_word({28'h0, flags}, 32'h00000000);
        rd_chk(`PEL_OFF_DEV_ERR_STATUS, 32'h00100000);
        finish_test();
    end
endmodule // tb

`default_nettype wire
